// ---- hdl/alc_top.sv ----
// Accessory command parser with APB registers and byte stream link
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module alc_top
  import alc_pkg::*;
#(
  parameter logic [7:0]  VER_MAJOR   = 8'h01,
  parameter logic [7:0]  VER_MINOR   = 8'h00,
  parameter logic [15:0] VER_RELEASE = 16'h0000,
  parameter logic [31:0] KEY_SEED    = 32'h1234ABCD
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic             nv_we,
  output logic [6:0]       nv_addr,
  output logic [7:0]       nv_wdata,
  output logic             irq,
  output logic             brake_present,
  output logic             brake_hold_when_powered,
  output logic             temp_sensor_present,
  output logic [2:0]       temp_sensor_kind_field,
  output logic             end_stop_one_present,
  output logic             end_stop_two_present,
  output logic             end_stop_one_low_true,
  output logic             end_stop_two_low_true,
  output logic             end_stops_joined
);

  alc_regs_t q;
  alc_regs_t d;
  alc_crc_if cif ();

  logic        setup;
  logic        access;
  logic        rx_fire;
  logic [31:0] code_in;
  logic [6:0]  len;
  logic [7:0]  byte_out;
  alc_rec_t    fixed;

  alc_crc u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  // Answer length per reply kind
  function automatic logic [6:0] reply_len(alc_reply_t k);
    case (k)
      ALC_R_ACC: return `ALC_LEN_ACC;
      ALC_R_VER: return `ALC_LEN_VER;
      ALC_R_KEY: return `ALC_LEN_KEY;
      default:   return `ALC_CODE_LEN;
    endcase
  endfunction

  // Leading four bytes: echo or error code
  function automatic logic [31:0] reply_code(alc_reply_t k,
                                             logic [31:0] c);
    case (k)
      ALC_R_ERRC: return `ALC_ANS_ERRC;
      ALC_R_ERRD: return `ALC_ANS_ERRD;
      ALC_R_ERRV: return `ALC_ANS_ERRV;
      default:    return c;
    endcase
  endfunction

  // Clamp flag words to defined bits; unknown sensor kind falls to unknown
  function automatic alc_rec_t sanitize(alc_rec_t r);
    alc_rec_t   f;
    logic [2:0] kind;
    f = r;
    for (int i = 1; i < `ALC_FLAG_BYTES; i++) begin
      f[`ALC_POS_BRAKE+i] = 8'h00;
      f[`ALC_POS_TEMP+i]  = 8'h00;
      f[`ALC_POS_STOP+i]  = 8'h00;
    end
    f[`ALC_POS_BRAKE] = r[`ALC_POS_BRAKE] & `ALC_BRAKE_MASK;
    kind = r[`ALC_POS_TEMP][`ALC_TEMP_KIND];
    if (kind > `ALC_KIND_SILICON) begin
      kind = `ALC_KIND_UNKNOWN;
    end
    f[`ALC_POS_TEMP] = (r[`ALC_POS_TEMP] & `ALC_TEMP_MASK);
    f[`ALC_POS_TEMP][`ALC_TEMP_KIND] = kind;
    f[`ALC_POS_STOP] = r[`ALC_POS_STOP] & `ALC_STOP_MASK;
    return f;
  endfunction

  assign setup   = psel & ~penable;
  assign access  = psel & penable & q.pready;
  assign rx_fire = rx_valid & q.rx_ready;
  assign code_in = {rx_data, q.cmd[31:8]};
  assign len     = reply_len(q.kind);
  assign fixed   = sanitize(q.stage);

  // Byte at the current answer position
  always_comb begin
    logic [31:0] code;
    code     = reply_code(q.kind, q.cmd);
    byte_out = 8'h00;
    if (q.idx < `ALC_CODE_LEN) begin
      byte_out = code[{q.idx[1:0], 3'b000} +: 8];
    end else if (q.idx == len - `ALC_CRC_BYTES) begin
      byte_out = cif.crc[7:0];
    end else if (q.idx == len - 7'd1) begin
      byte_out = cif.crc[15:8];
    end else begin
      case (q.kind)
        ALC_R_ACC: byte_out = q.rec[q.idx - `ALC_CODE_LEN];
        ALC_R_VER: begin
          case (q.idx[1:0])
            2'h0:    byte_out = VER_MAJOR;
            2'h1:    byte_out = VER_MINOR;
            2'h2:    byte_out = VER_RELEASE[7:0];
            default: byte_out = VER_RELEASE[15:8];
          endcase
        end
        ALC_R_KEY: begin
          // Key bytes tap the free-running generator; tail is reserved
          byte_out = (q.idx < `ALC_KEY_END) ? q.lfsr[7:0] : 8'h00;
        end
        default: byte_out = 8'h00;
      endcase
    end
  end

  // Next-state logic: bus slave first, so hardware sets win over clears
  always_comb begin
    d = q;
    d.lfsr = {q.lfsr[30:0],
              q.lfsr[31] ^ q.lfsr[21] ^ q.lfsr[1] ^ q.lfsr[0]};
    d.nv_we = 1'b0;
    cif.clr  = 1'b0;
    cif.en   = 1'b0;
    cif.data = 8'h00;

    // APB: answer decoded in setup, ready in the access cycle
    d.pready  = setup;
    d.pslverr = 1'b0;
    if (setup) begin
      d.prdata = 32'h0000_0000;
      if (paddr == `ALC_OFS_STATUS) begin
        d.prdata[`ALC_ST_W-1:0] = q.status;
      end else if (paddr == `ALC_OFS_MASK) begin
        d.prdata[`ALC_ST_W-1:0] = q.mask;
      end else if (paddr == `ALC_OFS_CTRL) begin
        d.prdata[`ALC_CTRL_UNLOCK] = q.unlock;
      end else if (paddr == `ALC_OFS_INFO) begin
        d.prdata[12:0] = {q.st, q.kind, q.idx};
      end else if (paddr == `ALC_OFS_VERSION) begin
        d.prdata = {VER_RELEASE, VER_MINOR, VER_MAJOR};
      end else if (paddr == `ALC_OFS_FLAGS) begin
        d.prdata[23:0] = {q.rec[`ALC_POS_STOP], q.rec[`ALC_POS_TEMP],
                          q.rec[`ALC_POS_BRAKE]};
      end else if (paddr == `ALC_OFS_LASTCMD) begin
        d.prdata = q.cmd;
      end else begin
        d.pslverr = 1'b1;
      end
    end
    if (access && pwrite) begin
      if (paddr == `ALC_OFS_STATUS) begin
        d.status = q.status & ~pwdata[`ALC_ST_W-1:0];
      end else if (paddr == `ALC_OFS_MASK) begin
        d.mask = pwdata[`ALC_ST_W-1:0];
      end else if (paddr == `ALC_OFS_CTRL) begin
        d.unlock = pwdata[`ALC_CTRL_UNLOCK];
      end
    end

    // Command parser
    case (q.st)
      ALC_S_CMD: begin
        d.rx_ready = 1'b1;
        if (rx_fire) begin
          d.cmd = code_in;
          d.idx = q.idx + 7'd1;
          if (q.idx == `ALC_CODE_LEN - 7'd1) begin
            d.idx = 7'd0;
            d.rx_ready = 1'b0;
            d.st = ALC_S_REPLY;
            cif.clr = 1'b1;
            if (code_in == `ALC_CMD_GETACC) begin
              d.kind = ALC_R_ACC;
            end else if (code_in == `ALC_CMD_BOOTVER) begin
              d.kind = ALC_R_VER;
            end else if (code_in == `ALC_CMD_RANDKEY) begin
              d.kind = ALC_R_KEY;
            end else if (code_in == `ALC_CMD_SETACC) begin
              d.rx_ready = 1'b1;
              d.st = ALC_S_DATA;
            end else begin
              d.kind = ALC_R_ERRC;
              d.status[`ALC_ST_ERRC] = 1'b1;
            end
          end
        end
      end
      ALC_S_DATA: begin
        // Staged so a bad frame never disturbs the stored record
        if (rx_fire) begin
          d.idx = q.idx + 7'd1;
          if (q.idx <= `ALC_DATA_LAST) begin
            d.stage[q.idx] = rx_data;
            cif.en   = 1'b1;
            cif.data = rx_data;
          end else if (q.idx == `ALC_CRC_LO) begin
            d.rx_crc[7:0] = rx_data;
          end else begin
            d.rx_crc[15:8] = rx_data;
            d.rx_ready = 1'b0;
            d.st = ALC_S_CHECK;
          end
        end
      end
      ALC_S_CHECK: begin
        d.idx = 7'd0;
        if (!q.unlock) begin
          // Store is for the manufacturer only; locked means refused
          d.kind = ALC_R_ERRC;
          d.status[`ALC_ST_ERRC] = 1'b1;
          d.st = ALC_S_REPLY;
          cif.clr = 1'b1;
        end else if (cif.crc != q.rx_crc) begin
          d.kind = ALC_R_ERRD;
          d.status[`ALC_ST_ERRD] = 1'b1;
          d.st = ALC_S_REPLY;
          cif.clr = 1'b1;
        end else begin
          d.rec = fixed;
          d.st  = ALC_S_SAVE;
          if (fixed != q.stage) begin
            d.kind = ALC_R_ERRV;
            d.status[`ALC_ST_ERRV] = 1'b1;
          end else begin
            d.kind = ALC_R_ECHO;
          end
        end
      end
      ALC_S_SAVE: begin
        d.nv_we    = 1'b1;
        d.nv_addr  = q.idx;
        d.nv_wdata = q.rec[q.idx];
        d.idx      = q.idx + 7'd1;
        if (q.idx == `ALC_DATA_LAST) begin
          d.idx = 7'd0;
          d.status[`ALC_ST_SAVED] = 1'b1;
          d.st = ALC_S_REPLY;
          cif.clr = 1'b1;
        end
      end
      ALC_S_REPLY: begin
        if (!q.tx_valid || tx_ready) begin
          if (q.idx == len) begin
            d.tx_valid = 1'b0;
            d.idx = 7'd0;
            d.rx_ready = 1'b1;
            d.st = ALC_S_CMD;
          end else begin
            d.tx_valid = 1'b1;
            d.tx_data  = byte_out;
            d.idx      = q.idx + 7'd1;
            // Checksum covers the data section only
            if (q.idx >= `ALC_CODE_LEN &&
                q.idx < len - `ALC_CRC_BYTES) begin
              cif.en   = 1'b1;
              cif.data = byte_out;
            end
          end
        end
      end
      default: d.st = ALC_S_CMD;
    endcase

    d.irq = |(d.status & d.mask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st   <= ALC_S_CMD;
      q.kind <= ALC_R_ECHO;
      q.lfsr <= KEY_SEED;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign rx_ready = q.rx_ready;
  assign tx_valid = q.tx_valid;
  assign tx_data  = q.tx_data;
  assign nv_we    = q.nv_we;
  assign nv_addr  = q.nv_addr;
  assign nv_wdata = q.nv_wdata;
  assign irq      = q.irq;
  assign brake_present           = q.rec[`ALC_POS_BRAKE][0];
  assign brake_hold_when_powered = q.rec[`ALC_POS_BRAKE][1];
  assign temp_sensor_present  = q.rec[`ALC_POS_TEMP][`ALC_TEMP_PRES];
  assign temp_sensor_kind_field = q.rec[`ALC_POS_TEMP][`ALC_TEMP_KIND];
  assign end_stop_one_present  = q.rec[`ALC_POS_STOP][0];
  assign end_stop_two_present  = q.rec[`ALC_POS_STOP][1];
  assign end_stop_one_low_true = q.rec[`ALC_POS_STOP][2];
  assign end_stop_two_low_true = q.rec[`ALC_POS_STOP][3];
  assign end_stops_joined      = q.rec[`ALC_POS_STOP][4];

endmodule // alc_top

`default_nettype wire

// ---- hdl/alc_params.svh ----
// Constants of the accessory loader command parser
`ifndef ALC_PARAMS_SVH
`define ALC_PARAMS_SVH

// Register byte offsets
`define ALC_OFS_STATUS   8'h00
`define ALC_OFS_MASK     8'h04
`define ALC_OFS_CTRL     8'h08
`define ALC_OFS_INFO     8'h0C
`define ALC_OFS_VERSION  8'h10
`define ALC_OFS_FLAGS    8'h14
`define ALC_OFS_LASTCMD  8'h18

// Status and mask bits, control unlock bit
`define ALC_ST_W         4
`define ALC_ST_ERRC      0
`define ALC_ST_ERRD      1
`define ALC_ST_ERRV      2
`define ALC_ST_SAVED     3
`define ALC_CTRL_UNLOCK  0

// Command and answer codes, first letter in the low byte
`define ALC_CMD_GETACC   32'h63636167
`define ALC_CMD_SETACC   32'h63636173
`define ALC_CMD_BOOTVER  32'h766C6267
`define ALC_CMD_RANDKEY  32'h646E7269
`define ALC_ANS_ERRC     32'h63727265
`define ALC_ANS_ERRD     32'h64727265
`define ALC_ANS_ERRV     32'h76727265

// Frame lengths in bytes
`define ALC_CODE_LEN     7'd4
`define ALC_DATA_LEN     108
`define ALC_DATA_LAST    7'd107
`define ALC_CRC_LO       7'd108
`define ALC_CRC_HI       7'd109
`define ALC_LEN_ACC      7'd114
`define ALC_LEN_VER      7'd10
`define ALC_LEN_KEY      7'd24
`define ALC_KEY_END      7'd20
`define ALC_CRC_BYTES    7'd2

// Byte positions inside the accessory data section
`define ALC_POS_BRAKE    36
`define ALC_POS_TEMP     76
`define ALC_POS_STOP     80
`define ALC_FLAG_BYTES   4

// Flag layouts
`define ALC_BRAKE_MASK   8'h03
`define ALC_TEMP_MASK    8'h0F
`define ALC_TEMP_KIND    2:0
`define ALC_TEMP_PRES    3
`define ALC_KIND_UNKNOWN 3'h0
`define ALC_KIND_JUNCT   3'h1
`define ALC_KIND_SILICON 3'h2
`define ALC_STOP_MASK    8'h1F

// Checksum: reflected 16-bit CRC
`define ALC_CRC_INIT     16'hFFFF
`define ALC_CRC_POLY     16'hA001

`endif

// ---- hdl/alc_pkg.sv ----
// Types shared by the accessory loader command parser
`include "alc_params.svh"

package alc_pkg;

  typedef enum logic [2:0] {
    ALC_S_CMD,
    ALC_S_DATA,
    ALC_S_CHECK,
    ALC_S_SAVE,
    ALC_S_REPLY
  } alc_state_t;

  typedef enum logic [2:0] {
    ALC_R_ECHO,
    ALC_R_ACC,
    ALC_R_VER,
    ALC_R_KEY,
    ALC_R_ERRC,
    ALC_R_ERRD,
    ALC_R_ERRV
  } alc_reply_t;

  typedef logic [`ALC_DATA_LEN-1:0][7:0] alc_rec_t;

  typedef struct packed {
    alc_state_t             st;
    alc_reply_t             kind;
    logic [6:0]             idx;
    logic [31:0]            cmd;
    alc_rec_t               rec;
    alc_rec_t               stage;
    logic [15:0]            rx_crc;
    logic [`ALC_ST_W-1:0]   status;
    logic [`ALC_ST_W-1:0]   mask;
    logic                   unlock;
    logic                   irq;
    logic                   rx_ready;
    logic                   tx_valid;
    logic [7:0]             tx_data;
    logic                   nv_we;
    logic [6:0]             nv_addr;
    logic [7:0]             nv_wdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            lfsr;
  } alc_regs_t;

endpackage

// ---- hdl/alc_crc_if.sv ----
// Checksum request and result between parser and checksum unit
`timescale 1ns/1ps
`default_nettype none

interface alc_crc_if;
  logic        clr;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;

  modport parser (output clr, output en, output data, input crc);
  modport engine (input clr, input en, input data, output crc);
endinterface

`default_nettype wire

// ---- hdl/alc_crc.sv ----
// Running 16-bit checksum over a byte stream
`timescale 1ns/1ps
`default_nettype none

module alc_crc
  import alc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  alc_crc_if.engine cif
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // One byte per cycle, low bit first
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `ALC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Clear wins over a byte in the same cycle
  always_comb begin
    crc_d = crc_q;
    if (cif.clr) begin
      crc_d = `ALC_CRC_INIT;
    end else if (cif.en) begin
      crc_d = crc_step(crc_q, cif.data);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= `ALC_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign cif.crc = crc_q;

endmodule // alc_crc

`default_nettype wire

// ---- tb/alc_props.sv ----
// Port checker for the accessory command parser
`timescale 1ns/1ps
`default_nettype none

module alc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic        nv_we,
  input wire logic [6:0]  nv_addr,
  input wire logic [2:0]  temp_sensor_kind_field
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answers exactly one cycle after setup, for one cycle
  a_apb_one_wait: assert property (psel && !penable |=> pready)
    else $error("pready not in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_refused: assert property (
    psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // Reply byte must not move while the host stalls
  a_tx_byte_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed under stall");
  a_no_rx_reply: assert property (tx_valid || nv_we |-> !rx_ready)
    else $error("receiver open during reply");
  a_kind_in_range: assert property (temp_sensor_kind_field <= 3'h2)
    else $error("sensor kind outside legal codes");
  a_nv_starts_zero: assert property ($rose(nv_we) |-> nv_addr == 7'd0)
    else $error("store does not start at byte zero");
  a_nv_walks_up: assert property (
    nv_we && nv_addr < 7'd107 |=> nv_we && nv_addr == $past(nv_addr) + 7'd1)
    else $error("store sequence broken");
  a_store_then_reply: assert property (
    nv_we && nv_addr == 7'd107 |-> ##[1:2] tx_valid
      && (tx_data == 8'h73 || tx_data == 8'h65))
    else $error("no reply after store");

  c_store_done: cover property (nv_we && nv_addr == 7'd107);
  c_refused: cover property (pready && pslverr);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule // alc_props

bind alc_top alc_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .nv_we(nv_we), .nv_addr(nv_addr),
  .temp_sensor_kind_field(temp_sensor_kind_field)
);

`default_nettype wire

// ---- tb/alc_host.sv ----
// Host model: sends command frames, sinks replies with random stalls
`timescale 1ns/1ps
`default_nettype none

module alc_host (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got[$];
  bit         stall_en;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    stall_en = 1'b0;
  end

  // Collect reply bytes; stalls a third of the cycles when asked
  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);
    tx_ready <= presetn && !(stall_en && $urandom_range(0, 2) == 0);
  end

  // Whole frame, byte held until taken; code low byte first
  task automatic send_frame(input logic [7:0] q[$]);
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= q[i];
      do @(posedge pclk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~q[q.size()-1]; // Released line no longer shows last byte
  endtask
endmodule // alc_host

`default_nettype wire

// ---- tb/alc_top_tb.sv ----
// Self-checking bench for the accessory command parser
`timescale 1ns/1ps
`default_nettype none
`include "alc_params.svh"

module alc_top_tb;
  localparam logic [7:0]  MAJ = 8'h03;
  localparam logic [7:0]  MIN = 8'h07;
  localparam logic [15:0] REL = 16'h0102;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, nv_we, irq, rd_e;
  logic [7:0]  paddr, rx_data, tx_data, nv_wdata;
  logic [6:0]  nv_addr;
  logic [31:0] pwdata, prdata, rd_v;
  wire  [10:0] flg;
  logic [7:0]  nv_mem [128];
  logic [7:0]  tx_q[$], ex_q[$], rec[$], b_q[$];
  int          nv_cnt, err_count, tests_run;

  alc_top #(.VER_MAJOR(MAJ), .VER_MINOR(MIN), .VER_RELEASE(REL)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .nv_we(nv_we),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .irq(irq),
    .brake_present(flg[0]), .brake_hold_when_powered(flg[1]),
    .temp_sensor_kind_field(flg[4:2]), .temp_sensor_present(flg[5]),
    .end_stop_one_present(flg[6]), .end_stop_two_present(flg[7]),
    .end_stop_one_low_true(flg[8]), .end_stop_two_low_true(flg[9]),
    .end_stops_joined(flg[10]));

  alc_host hst (.pclk(pclk), .presetn(presetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Stand-in for the nonvolatile store
  always @(posedge pclk) begin
    if (nv_we === 1'b1) begin
      nv_mem[nv_addr] <= nv_wdata;
      nv_cnt <= nv_cnt + 1;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Reflected 16-bit sum, low bit first
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction

  function automatic void put(ref logic [7:0] q[$], input logic [31:0] w,
                              input int n);
    for (int i = 0; i < n; i++) q.push_back(w[8*i +: 8]);
  endfunction

  // One bus transfer, idle cycle after, so calls never collide
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit here: a missing answer is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_v);
    chk("pslverr", {31'h0, a > 8'h18}, {31'h0, rd_e});
  endtask

  // Send tx_q, wait for len reply bytes, compare the ex_q prefix
  task automatic cmd(input string nm, input int len);
    hst.got.delete();
    hst.send_frame(tx_q);
    while (hst.got.size() < len || rx_ready !== 1'b1) begin
      @(posedge pclk);
    end
    chk({nm, " length"}, len, hst.got.size());
    foreach (ex_q[i]) chk(nm, ex_q[i], hst.got[i]);
    $display("test %s done", nm);
  endtask

  task automatic query(input string nm, input logic [31:0] c, input int len);
    tx_q.delete();
    put(tx_q, c, 4);
    cmd(nm, len);
  endtask

  task automatic sacc(input logic [15:0] flip, input logic [31:0] ans);
    nv_cnt = 0;
    tx_q.delete();
    ex_q.delete();
    put(tx_q, `ALC_CMD_SETACC, 4);
    foreach (rec[i]) tx_q.push_back(rec[i]);
    put(tx_q, {16'h0, crc(rec) ^ flip}, 2);
    put(ex_q, ans, 4);
    cmd("store", 4);
  endtask

  // Random record with legal flag words, or every flag word overrun
  task automatic mkrec(input bit bad);
    rec.delete();
    repeat (108) rec.push_back(8'($urandom));
    for (int i = 1; i < 4; i++) begin
      rec[36+i] = 8'h00;
      rec[76+i] = 8'h00;
      rec[80+i] = 8'h00;
    end
    rec[36] = bad ? 8'hFF : rec[36] & 8'h03;
    rec[76] = bad ? 8'h0F : {4'h0, rec[76][3], 3'(rec[76][2:0] % 3)};
    rec[80] = bad ? 8'hFF : rec[80] & 8'h1F;
  endtask

  // Stored bytes, flag pins and flag register against rec
  task automatic verify();
    chk("stored count", 108, nv_cnt);
    foreach (rec[i]) chk("stored byte", rec[i], nv_mem[i]);
    chk("flag pins", {rec[80][4:0], rec[76][3:0], rec[36][1:0]}, flg);
    rd("flags reg", `ALC_OFS_FLAGS, {8'h0, rec[80], rec[76], rec[36]});
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    summarize();
  end

  initial begin
    void'($urandom(41));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {nv_cnt, err_count, tests_run} = '0;
    repeat (12) @(posedge pclk);
    chk("rx_ready in reset", 32'h0, rx_ready);
    chk("flags in reset", 32'h0, flg);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd("status", `ALC_OFS_STATUS, 32'h0);
    rd("mask", `ALC_OFS_MASK, 32'h0);
    rd("version", `ALC_OFS_VERSION, {REL, MIN, MAJ});
    rd("unmapped", 8'h1C, 32'h0);
    $display("test registers done");
    // Unknown code raises error, irq, then cleared by write-one
    apb(1'b1, `ALC_OFS_MASK, 32'hF);
    ex_q.delete();
    put(ex_q, `ALC_ANS_ERRC, 4);
    query("unknown", {24'($urandom), 8'h71}, 4);
    chk("irq raised", 32'h1, irq);
    rd("status errc", `ALC_OFS_STATUS, 32'h1);
    apb(1'b1, `ALC_OFS_STATUS, 32'h1);
    chk("irq cleared", 32'h0, irq);
    hst.stall_en = 1'b1;
    b_q.delete();
    put(b_q, {REL, MIN, MAJ}, 4);
    ex_q.delete();
    put(ex_q, `ALC_CMD_BOOTVER, 4);
    ex_q = {ex_q, b_q};
    put(ex_q, {16'h0, crc(b_q)}, 2);
    query("bootver", `ALC_CMD_BOOTVER, 10);
    ex_q.delete();
    put(ex_q, `ALC_CMD_RANDKEY, 4);
    query("randkey", `ALC_CMD_RANDKEY, 24);
    chk("key reserved", 32'h0, {hst.got[21], hst.got[20]});
    chk("key sum", crc(hst.got[4:21]), {hst.got[23], hst.got[22]});
    // Locked store refused while irq is masked
    apb(1'b1, `ALC_OFS_MASK, 32'h0);
    mkrec(1'b0);
    sacc(16'h0, `ALC_ANS_ERRC);
    chk("irq masked", 32'h0, irq);
    chk("locked store", 32'h0, nv_cnt);
    apb(1'b1, `ALC_OFS_MASK, 32'h1);
    chk("irq unmasked", 32'h1, irq);
    apb(1'b1, `ALC_OFS_STATUS, 32'hF);
    apb(1'b1, `ALC_OFS_CTRL, 32'h1);
    rd("ctrl", `ALC_OFS_CTRL, 32'h1);
    sacc(16'h0, `ALC_CMD_SETACC);
    verify();
    rd("status saved", `ALC_OFS_STATUS, 32'h8);
    ex_q.delete();
    put(ex_q, `ALC_CMD_GETACC, 4);
    ex_q = {ex_q, rec};
    put(ex_q, {16'h0, crc(rec)}, 2);
    query("getacc", `ALC_CMD_GETACC, 114);
    rd("last code", `ALC_OFS_LASTCMD, `ALC_CMD_GETACC);
    // Corrupted sum must store nothing
    apb(1'b1, `ALC_OFS_STATUS, 32'hF);
    sacc(16'h0001, `ALC_ANS_ERRD);
    chk("bad sum store", 32'h0, nv_cnt);
    rd("status errd", `ALC_OFS_STATUS, 32'h2);
    // Overrun flags are substituted and still stored
    apb(1'b1, `ALC_OFS_STATUS, 32'hF);
    mkrec(1'b1);
    sacc(16'h0, `ALC_ANS_ERRV);
    rd("status errv", `ALC_OFS_STATUS, 32'hC);
    rec[36] = 8'h03;
    rec[76] = 8'h08;
    rec[80] = 8'h1F;
    verify();
    summarize();
  end
endmodule // alc_top_tb

`default_nettype wire
